// [rtl/ocs_pkg.sv]
// Package for the oscillator enable and clock select block.
// Assumes one 250 MHz clock and a synchronous active-low reset.
package ocs_pkg;
  localparam int REG_AW = 2;
  localparam logic [REG_AW-1:0] OFF_SYS_CLK = 2'h0;
  localparam logic [REG_AW-1:0] OFF_IRC = 2'h1;
  localparam logic [REG_AW-1:0] OFF_FXT = 2'h2;
  localparam logic [REG_AW-1:0] OFF_SXT = 2'h3;
  // System clock control fields
  localparam int SCC_DIV_LSB = 5;
  localparam int SCC_HFS_BIT = 3;
  localparam int SCC_LFS_BIT = 2;
  localparam int SCC_HIDLE_BIT = 1;
  localparam int SCC_LIDLE_BIT = 0;
  // Oscillator control fields
  localparam int IRC_FREQ_LSB = 2;
  localparam int FLAG_BIT = 1;
  localparam int EN_BIT = 0;
  localparam int MODE_BIT = 2;
  // Reset values and field codes
  localparam logic [2:0] RST_DIV = 3'h0;
  localparam logic [1:0] RST_IRC_FREQ = 2'h0;
  localparam logic RST_IRC_EN = 1'b1;
  localparam logic [2:0] DIV_SUB = 3'h7;
  localparam logic [1:0] IRC_8M = 2'h0;
  localparam logic [1:0] IRC_12M = 2'h1;
  localparam logic [1:0] IRC_16M = 2'h2;
  // Timing
  localparam int CLK_MHZ = 250;
  localparam int SWITCH_SYS_PERIODS = 4;
  localparam int SWITCH_CYC = SWITCH_SYS_PERIODS + 2;
  localparam int SETTLE_US = 1;
  localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;
  localparam int CNT_W = 12;
  localparam int SW_W = 3;

  typedef struct packed {
    logic [2:0] div;
    logic hf_sel;
    logic lf_sel;
    logic hs_idle_keep;
    logic ls_idle_keep;
  } ocs_scc_t;

  typedef struct packed {
    logic irc_on;
    logic [1:0] irc_freq;
    logic fxt_on;
    logic fxt_high_drive;
    logic sxt_on;
    logic fast_src_xtal;
    logic slow_src_xtal;
    logic [2:0] div;
    logic cpu_run;
  } ocs_clk_ctrl_t;
endpackage : ocs_pkg

// [rtl/ocs_settle.sv]
// Stable-flag generator for one oscillator.
// Assumes restart is a one-cycle pulse on the same clock.
module ocs_settle
  import ocs_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic enable_in,
  input wire logic restart_in,
  output logic stable_out
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic stable;
  } ocs_settle_st_t;

  ocs_settle_st_t st_r;
  ocs_settle_st_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (!enable_in || restart_in) begin
      st_nxt.cnt = CNT_W'(SETTLE_CYC);
      st_nxt.stable = 1'b0;
    end else if (st_r.cnt != '0) begin
      st_nxt.cnt = st_r.cnt - 1'b1;
    end else begin
      st_nxt.stable = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      st_r <= '{cnt: CNT_W'(SETTLE_CYC), stable: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign stable_out = st_r.stable;
endmodule : ocs_settle

// [rtl/ocs_switch.sv]
// Clock switch sequencer: applies a new selection after a fixed delay.
// Assumes request is a level selection on the same clock.
module ocs_switch
  import ocs_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic [4:0] req_in,
  output logic [4:0] applied_out,
  output logic busy_out
);
  typedef struct packed {
    logic [4:0] applied;
    logic [SW_W-1:0] cnt;
    logic busy;
  } ocs_sw_st_t;

  ocs_sw_st_t st_r;
  ocs_sw_st_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (req_in != st_r.applied && !st_r.busy) begin
      st_nxt.busy = 1'b1;
      // Two of the cycles go to the output register stages
      st_nxt.cnt = SW_W'(SWITCH_CYC - 3);
    end else if (st_r.busy) begin
      if (st_r.cnt == '0) begin
        st_nxt.busy = 1'b0;
        st_nxt.applied = req_in;
      end else begin
        st_nxt.cnt = st_r.cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      st_r <= '{applied: {RST_DIV, 2'b00}, cnt: '0, busy: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign applied_out = st_r.applied;
  assign busy_out = st_r.busy;
endmodule : ocs_switch

// [rtl/ocs_top.sv]
// Oscillator enable and system clock select registers and control.
// Assumes a plain register port on the 250 MHz system clock; halt and
// crystal pin enable arrive from logic on the same clock.
// Behaviour
// [RULE_01] High idle bit keeps the fast oscillator running during halt.
// [RULE_02] Low idle bit keeps the slow oscillator running during halt.
// [RULE_03] Low select 0 picks internal slow RC, 1 the slow crystal.
// [RULE_04] Clock changes complete after a short fixed switching delay.
// [RULE_05] Internal RC frequency field: 00 8MHz, 01 12MHz, 10 16MHz.
// [RULE_06] New internal RC frequency applies only once its stable flag is high.
// [RULE_07] Internal RC flag clears then sets on enable or frequency write; the code restarts it on a rising enable or a write that changes the frequency.
// [RULE_08] Internal RC enable switches the oscillator, resets to one.
// [RULE_09] Drive mode bit: 0 low drive up to 10MHz, 1 high drive.
// [RULE_10] Drive mode writes ignored while crystal pins enabled and crystal on.
// [RULE_11] Software sets drive mode before enabling the fast crystal.
// [RULE_12] Fast crystal flag clears then sets on enable.
// [RULE_13] Fast crystal enable switches the fast crystal.
// [RULE_14] Slow crystal speed-up bit reads fixed one.
// [RULE_15] Slow crystal flag clears then sets on enable.
// [RULE_16] Slow crystal enable switches the slow crystal.
// [RULE_17] Unimplemented upper bits read zero.
// [RULE_18] Divider codes 0-6 divide fast clock by 1..64, code 7 sub-clock.
// [RULE_19] High select picks fast crystal or internal RC.
// [RULE_20] Halt with both idle bits low enters sleep, sub-clock stopped.
// [RULE_21] Stable flags read zero while disabled and after reset.
//
// Decided for this implementation: the register offsets and the address-and-strobe port.
module ocs_top
  import ocs_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic [ocs_pkg::REG_AW-1:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  input wire logic halt_in,
  input wire logic wake_in,
  input wire logic xtal_pins_en_in,
  output ocs_pkg::ocs_clk_ctrl_t clk_ctrl_out,
  output logic sub_clk_periph_en_out,
  output logic sleep_out,
  output logic switch_busy_out
);
  import ocs_pkg::*;

  typedef struct packed {
    ocs_scc_t system_clock_control;
    logic [1:0] irc_freq;
    logic [1:0] irc_freq_applied;
    logic irc_en;
    logic fxt_mode;
    logic fxt_en;
    logic sxt_en;
    logic halted;
    logic irc_restart;
    logic fxt_restart;
    logic sxt_restart;
    logic [7:0] rdata;
    ocs_clk_ctrl_t ctrl;
    logic sub_en;
    logic sleep;
    logic busy;
  } ocs_st_t;

  ocs_st_t st_r;
  ocs_st_t st_nxt;
  logic irc_stable;
  logic fxt_stable;
  logic sxt_stable;
  logic [4:0] sw_applied;
  logic sw_busy;
  logic [7:0] rd_mux;
  logic fast_on;
  logic slow_on;
  logic [2:0] app_div;
  logic app_hfs;
  logic app_lfs;

  ocs_settle u_irc_settle (
    .sys_clk_in(sys_clk_in),
    .resetn_in(resetn_in),
    .enable_in(st_r.ctrl.irc_on),
    .restart_in(st_r.irc_restart),
    .stable_out(irc_stable)
  );

  ocs_settle u_fxt_settle (
    .sys_clk_in(sys_clk_in),
    .resetn_in(resetn_in),
    .enable_in(st_r.ctrl.fxt_on),
    .restart_in(st_r.fxt_restart),
    .stable_out(fxt_stable)
  );

  ocs_settle u_sxt_settle (
    .sys_clk_in(sys_clk_in),
    .resetn_in(resetn_in),
    .enable_in(st_r.ctrl.sxt_on),
    .restart_in(st_r.sxt_restart),
    .stable_out(sxt_stable)
  );

  ocs_switch u_switch (
    .sys_clk_in(sys_clk_in),
    .resetn_in(resetn_in),
    .req_in({st_r.system_clock_control.div, st_r.system_clock_control.hf_sel, st_r.system_clock_control.lf_sel}), // [RULE_04]
    .applied_out(sw_applied),
    .busy_out(sw_busy)
  );

  assign app_div = sw_applied[4:2];
  assign app_hfs = sw_applied[1];
  assign app_lfs = sw_applied[0];

  // Read mux; flags gated by the enables
  always_comb begin
    rd_mux = 8'h00; // [RULE_17]
    case (reg_addr_in)
      OFF_SYS_CLK: begin
        rd_mux[SCC_DIV_LSB +: 3] = st_r.system_clock_control.div;
        rd_mux[SCC_HFS_BIT] = st_r.system_clock_control.hf_sel;
        rd_mux[SCC_LFS_BIT] = st_r.system_clock_control.lf_sel;
        rd_mux[SCC_HIDLE_BIT] = st_r.system_clock_control.hs_idle_keep;
        rd_mux[SCC_LIDLE_BIT] = st_r.system_clock_control.ls_idle_keep;
      end
      OFF_IRC: begin
        rd_mux[IRC_FREQ_LSB +: 2] = st_r.irc_freq;
        rd_mux[FLAG_BIT] = irc_stable & st_r.irc_en & ~st_r.irc_restart; // [RULE_07] [RULE_21]
        rd_mux[EN_BIT] = st_r.irc_en;
      end
      OFF_FXT: begin
        rd_mux[MODE_BIT] = st_r.fxt_mode;
        rd_mux[FLAG_BIT] = fxt_stable & st_r.fxt_en & ~st_r.fxt_restart; // [RULE_12] [RULE_21]
        rd_mux[EN_BIT] = st_r.fxt_en;
      end
      OFF_SXT: begin
        rd_mux[MODE_BIT] = 1'b1; // [RULE_14]
        rd_mux[FLAG_BIT] = sxt_stable & st_r.sxt_en & ~st_r.sxt_restart; // [RULE_15] [RULE_21]
        rd_mux[EN_BIT] = st_r.sxt_en;
      end
      default: rd_mux = 8'h00;
    endcase
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.irc_restart = 1'b0;
    st_nxt.fxt_restart = 1'b0;
    st_nxt.sxt_restart = 1'b0;
    st_nxt.rdata = reg_rd_in ? rd_mux : 8'h00;

    if (reg_wr_in) begin
      case (reg_addr_in)
        OFF_SYS_CLK: begin
          st_nxt.system_clock_control.div = reg_wdata_in[SCC_DIV_LSB +: 3];
          st_nxt.system_clock_control.hf_sel = reg_wdata_in[SCC_HFS_BIT];
          st_nxt.system_clock_control.lf_sel = reg_wdata_in[SCC_LFS_BIT];
          st_nxt.system_clock_control.hs_idle_keep = reg_wdata_in[SCC_HIDLE_BIT];
          st_nxt.system_clock_control.ls_idle_keep = reg_wdata_in[SCC_LIDLE_BIT];
        end
        OFF_IRC: begin
          st_nxt.irc_freq = reg_wdata_in[IRC_FREQ_LSB +: 2]; // [RULE_05]
          st_nxt.irc_en = reg_wdata_in[EN_BIT]; // [RULE_08]
          // Restart on rising enable or on a write that changes the frequency
          if ((reg_wdata_in[EN_BIT] && !st_r.irc_en)
              || reg_wdata_in[IRC_FREQ_LSB +: 2] != st_r.irc_freq) begin
            st_nxt.irc_restart = 1'b1; // [RULE_07]
          end
        end
        OFF_FXT: begin
          if (!(xtal_pins_en_in && st_r.fxt_en)) begin
            st_nxt.fxt_mode = reg_wdata_in[MODE_BIT]; // [RULE_10]
          end
          st_nxt.fxt_en = reg_wdata_in[EN_BIT]; // [RULE_13]
          if (reg_wdata_in[EN_BIT] && !st_r.fxt_en) begin
            st_nxt.fxt_restart = 1'b1; // [RULE_12]
          end
        end
        OFF_SXT: begin
          st_nxt.sxt_en = reg_wdata_in[EN_BIT]; // [RULE_16]
          if (reg_wdata_in[EN_BIT] && !st_r.sxt_en) begin
            st_nxt.sxt_restart = 1'b1; // [RULE_15]
          end
        end
        default: begin
        end
      endcase
    end

    // Frequency takes effect once the RC reports stable
    if (irc_stable && st_r.irc_en && !st_r.irc_restart) begin
      st_nxt.irc_freq_applied = st_r.irc_freq; // [RULE_06]
    end

    // Halt and wake
    if (wake_in) begin
      st_nxt.halted = 1'b0;
    end else if (halt_in) begin
      st_nxt.halted = 1'b1;
    end

    // Selected sources follow their enables unless halted without idle keep
    fast_on = st_r.halted ? st_r.system_clock_control.hs_idle_keep : 1'b1; // [RULE_01]
    slow_on = st_r.halted ? st_r.system_clock_control.ls_idle_keep : 1'b1; // [RULE_02]

    st_nxt.ctrl.irc_on = st_r.irc_en && (fast_on || !app_hfs); // [RULE_08] [RULE_19]
    st_nxt.ctrl.irc_freq = st_r.irc_freq_applied; // [RULE_05]
    st_nxt.ctrl.fxt_on = st_r.fxt_en && (fast_on || app_hfs); // [RULE_13]
    st_nxt.ctrl.fxt_high_drive = st_r.fxt_mode; // [RULE_09]
    st_nxt.ctrl.sxt_on = st_r.sxt_en && (slow_on || !app_lfs); // [RULE_16]
    st_nxt.ctrl.fast_src_xtal = ~app_hfs; // [RULE_19]
    st_nxt.ctrl.slow_src_xtal = app_lfs; // [RULE_03]
    st_nxt.ctrl.div = app_div; // [RULE_18]
    st_nxt.ctrl.cpu_run = ~st_r.halted;
    st_nxt.sub_en = slow_on; // [RULE_02]
    st_nxt.sleep = st_r.halted && !st_r.system_clock_control.hs_idle_keep && !st_r.system_clock_control.ls_idle_keep; // [RULE_20]
    st_nxt.busy = sw_busy; // [RULE_04]
  end

  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      st_r <= '0;
      st_r.system_clock_control.div <= RST_DIV;
      st_r.irc_freq <= RST_IRC_FREQ;
      st_r.irc_freq_applied <= RST_IRC_FREQ;
      st_r.irc_en <= RST_IRC_EN; // [RULE_08]
      st_r.irc_restart <= 1'b1;
      st_r.ctrl.irc_on <= RST_IRC_EN;
      st_r.ctrl.fast_src_xtal <= 1'b1;
      st_r.ctrl.cpu_run <= 1'b1;
      st_r.sub_en <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata_out = st_r.rdata;
  assign clk_ctrl_out = st_r.ctrl;
  assign sub_clk_periph_en_out = st_r.sub_en;
  assign sleep_out = st_r.sleep;
  assign switch_busy_out = st_r.busy;
endmodule : ocs_top

// [testbench/ocs_properties.sv]
// Port checker for the oscillator and clock select block.
// Assumes it is bound to ocs_top and sees only its ports.
module ocs_properties (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic [ocs_pkg::REG_AW-1:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic halt_in,
  input wire logic wake_in,
  input wire logic xtal_pins_en_in,
  input wire ocs_pkg::ocs_clk_ctrl_t clk_ctrl_out,
  input wire logic sub_clk_periph_en_out,
  input wire logic sleep_out,
  input wire logic switch_busy_out
);
  import ocs_pkg::*;
  logic [7:0] scc_sh_r;
  logic sw_match;
  // Last value written to the system clock register
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      scc_sh_r <= 8'h00;
    end else if (reg_wr_in && reg_addr_in == OFF_SYS_CLK) begin
      scc_sh_r <= reg_wdata_in;
    end
  end
  assign sw_match = clk_ctrl_out.div == scc_sh_r[7:5] &&
    clk_ctrl_out.fast_src_xtal == !scc_sh_r[3] && clk_ctrl_out.slow_src_xtal == scc_sh_r[2];
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!resetn_in);
  sequence s_halt;
    halt_in && !wake_in;
  endsequence
  sequence s_scc_wr;
    reg_wr_in && reg_addr_in == OFF_SYS_CLK && !switch_busy_out;
  endsequence
  a_rdata_idle_zero: assert property (!reg_rd_in |=> reg_rdata_out == 8'h00)
    else $error("read data not zero outside a read");
  a_upper_bits_zero: assert property (reg_rd_in && reg_addr_in != OFF_SYS_CLK
    |=> reg_rdata_out[7:4] == 4'h0) else $error("upper bits not zero");
  a_speedup_fixed: assert property (reg_rd_in && reg_addr_in == OFF_SXT
    |=> reg_rdata_out[3:2] == 2'h1) else $error("speed-up bit not one");
  a_halt_stops_cpu: assert property (s_halt |-> ##2 !clk_ctrl_out.cpu_run)
    else $error("cpu still running after halt");
  a_sleep_needs_idle: assert property ($rose(sleep_out) |-> scc_sh_r[1:0] == 2'h0)
    else $error("sleep with an idle bit set");
  a_switch_delay: assert property (s_scc_wr |-> ##[1:7] sw_match)
    else $error("clock switch too slow");
  a_busy_bounded: assert property ($rose(switch_busy_out) |-> ##[1:12] !switch_busy_out)
    else $error("switch busy too long");
  a_div_on_switch: assert property ($changed(clk_ctrl_out.div)
    |-> $past(switch_busy_out) || $past(switch_busy_out, 2)) else $error("divider changed idle");
endmodule : ocs_properties

bind ocs_top ocs_properties u_props (.sys_clk_in, .resetn_in, .reg_addr_in, .reg_wdata_in,
  .reg_wr_in, .reg_rd_in, .reg_rdata_out, .halt_in, .wake_in, .xtal_pins_en_in,
  .clk_ctrl_out, .sub_clk_periph_en_out, .sleep_out, .switch_busy_out);

// [testbench/tb_osc_enable_and_clock_select.sv]
// Self-checking bench for the oscillator and clock select block.
// Assumes the checker is bound through its own file.
module tb_osc_enable_and_clock_select;
  timeunit 1ns;
  timeprecision 1ps;
  import ocs_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic halt = 1'b0;
  logic wake = 1'b0;
  logic pins = 1'b0;
  logic [7:0] rdat;
  ocs_clk_ctrl_t cc;
  logic sub_en;
  logic slp;
  logic busy;
  int n_errors = 0;
  int n_tests = 0;
  always #2 clk = ~clk;
  ocs_top dut (.sys_clk_in(clk), .resetn_in(resetn), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr_stb), .reg_rd_in(rd_stb), .reg_rdata_out(rdat), .halt_in(halt),
    .wake_in(wake), .xtal_pins_en_in(pins), .clk_ctrl_out(cc), .sub_clk_periph_en_out(sub_en),
    .sleep_out(slp), .switch_busy_out(busy));
  task report_and_stop;
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop
  task chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    n_tests++;
    if (s !== e) begin
      n_errors++;
      $display("unexpected %s exp %h got %h", nm, e, s);
    end
  endtask : chk
  task reg_write(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask : reg_write
  task rchk(input string nm, input logic [1:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 chk(nm, rdat, e);
  endtask : rchk
  task wait_flag(input logic [1:0] a);
    for (int i = 0; i < 400; i++) begin
      @(posedge clk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge clk);
      rd_stb <= 1'b0;
      #1;
      if (rdat[1] === 1'b1) return;
    end
    chk("flag timeout", 8'h00, 8'h01);
    report_and_stop;
  endtask : wait_flag
  task t_reset;
    rchk("scc", OFF_SYS_CLK, 8'h00);
    rchk("irc", OFF_IRC, 8'h01);
    rchk("fxt", OFF_FXT, 8'h00);
    rchk("sxt", OFF_SXT, 8'h04);
    chk("run", {6'h0, cc.irc_on, cc.cpu_run}, 8'h03);
  endtask : t_reset
  task t_irc;
    logic [1:0] f[3] = '{IRC_12M, IRC_16M, IRC_8M};
    logic [1:0] prev = IRC_8M;
    wait_flag(OFF_IRC);
    foreach (f[i]) begin
      reg_write(OFF_IRC, {4'h0, f[i], 2'h1});
      rchk("irc restart", OFF_IRC, {4'h0, f[i], 2'h1});
      chk("freq held", {6'h0, cc.irc_freq}, {6'h0, prev});
      wait_flag(OFF_IRC);
      repeat (2) @(posedge clk);
      #1 chk("freq", {6'h0, cc.irc_freq}, {6'h0, f[i]});
      prev = f[i];
    end
    reg_write(OFF_IRC, 8'h00);
    rchk("irc off", OFF_IRC, 8'h00);
    chk("irc on", {7'h0, cc.irc_on}, 8'h00);
    reg_write(OFF_IRC, 8'h01);
    rchk("irc again", OFF_IRC, 8'h01);
    wait_flag(OFF_IRC);
  endtask : t_irc
  task t_fxt;
    @(posedge clk);
    pins <= 1'b1;
    reg_write(OFF_FXT, 8'h04); // Drive mode chosen before enable
    rchk("mode", OFF_FXT, 8'h04);
    reg_write(OFF_FXT, 8'h05);
    rchk("fxt start", OFF_FXT, 8'h05);
    wait_flag(OFF_FXT);
    chk("fxt on", {6'h0, cc.fxt_on, cc.fxt_high_drive}, 8'h03);
    reg_write(OFF_FXT, 8'h01);
    rchk("mode locked", OFF_FXT, 8'h07);
    @(posedge clk);
    pins <= 1'b0;
    reg_write(OFF_FXT, 8'h01);
    rchk("mode free", OFF_FXT, 8'h03);
    reg_write(OFF_FXT, 8'h00);
    rchk("fxt off", OFF_FXT, 8'h00);
  endtask : t_fxt
  task t_sxt;
    reg_write(OFF_SXT, 8'h01);
    rchk("sxt start", OFF_SXT, 8'h05);
    wait_flag(OFF_SXT);
    chk("sxt on", {7'h0, cc.sxt_on}, 8'h01);
    reg_write(OFF_SXT, 8'h00);
    rchk("sxt off", OFF_SXT, 8'h04);
  endtask : t_sxt
  task t_switch;
    logic [7:0] v;
    for (int i = 1; i < 9; i++) begin
      v = {i[2:0], 1'b0, i[1], i[0], 2'h0};
      reg_write(OFF_SYS_CLK, v);
      repeat (3) @(posedge clk);
      #1 chk("busy", {7'h0, busy}, 8'h01);
      repeat (3) @(posedge clk);
      #1 chk("switch", {cc.div, 1'b0, !cc.fast_src_xtal, cc.slow_src_xtal, 2'h0}, v);
      chk("busy done", {7'h0, busy}, 8'h00);
      rchk("scc", OFF_SYS_CLK, v);
    end
  endtask : t_switch
  task t_halt;
    for (int m = 0; m < 4; m++) begin
      reg_write(OFF_SYS_CLK, {6'h02, m[1:0]});
      repeat (12) @(posedge clk);
      halt <= 1'b1;
      @(posedge clk);
      halt <= 1'b0;
      repeat (3) @(posedge clk);
      #1 chk("halt", {4'h0, cc.cpu_run, slp, cc.irc_on, sub_en}, {5'h0, m == 0, m[1:0]});
      @(posedge clk);
      wake <= 1'b1;
      @(posedge clk);
      wake <= 1'b0;
      repeat (3) @(posedge clk);
      #1 chk("wake", {6'h0, cc.cpu_run, slp}, 8'h02);
    end
  endtask : t_halt
  initial begin
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    t_reset;
    t_irc;
    t_fxt;
    t_sxt;
    t_switch;
    t_halt;
    report_and_stop;
  end
endmodule : tb_osc_enable_and_clock_select
